// File: shared/epc_pkg.sv
package epc_pkg;

  // cpu bus widths
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 8;

  // register and array placement
  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 14'h001d;
  localparam logic [ADDR_W-1:0] EPROM_FIRST = 14'h2000;
  localparam logic [ADDR_W-1:0] EPROM_LAST  = 14'h3eff;

  // control register field positions
  localparam int unsigned LATCH_BIT = 1;
  localparam int unsigned POWER_BIT = 0;

  // reset and idle values
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = 14'h0000;

  // cpu access toward the block
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
  } epc_bus_req_type;

  // drive toward the eprom array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              read_en;
    logic              prog_mode;
    logic              prog_power;
  } epc_array_type;

endpackage

// File: rtl/epc_sync3.sv
`timescale 1ns/1ps
module epc_sync3 (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic pin_in,
  output logic      level_out
);

  // three flops plus agreed level
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } epc_sync_type;

  epc_sync_type st_q;
  epc_sync_type st_d;

  // level follows only when second and third stages agree
  always_comb begin
    st_d       = st_q;
    st_d.s1    = pin_in;
    st_d.s2    = st_q.s1;
    st_d.s3    = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.level = st_q.s3;
    end
  end

  // reset assumes no supply present
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;

endmodule

// File: rtl/epc_prog_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] 8-bit control register, latch enable bit 1, power bit 0, both reset zero.
// [R2] latch enable set: cpu write to array captures address and data.
// [R3] latch enable set: array in programming mode, reads return no contents.
// [R4] latch enable cannot be set while no programming voltage is present.
// [R5] latch enable clear: path routed for reads, array writes not latched.
// [R6] power bit one drives the programming power control on.
// [R7] power bit forced zero whenever latch enable is not one.
// [R8] power bit zero keeps programming power control off.
// [R9] software: latch, write data, power on, wait, then clear both bits.
// [R10] one write clearing both bits ends a programming cycle.
// [R11] upper six bits read zero, writes to them ignored.
module epc_prog_ctrl
  import epc_pkg::*;
#(
  parameter int unsigned ADDR_BITS = ADDR_W,
  parameter int unsigned DATA_BITS = DATA_W
)
(
  input  wire logic            core_clk,
  input  wire logic            nrst,
  input  wire epc_bus_req_type bus_req,
  output logic [DATA_W-1:0]    bus_rdata,
  input  wire logic            vpp_present,
  input  wire logic [DATA_W-1:0] array_rdata,
  output epc_array_type        array_out,
  output logic                 latch_valid
);

  // whole state of the block
  typedef struct packed {
    logic              latch_en;
    logic              power_cmd;
    logic [ADDR_W-1:0] lat_addr;
    logic [DATA_W-1:0] lat_data;
    logic              lat_valid;
    logic [DATA_W-1:0] rdata;
  } epc_state_type;

  epc_state_type st_q;
  epc_state_type st_d;
  logic          vpp_ok;
  logic          hit_ctrl;
  logic          hit_array;
  logic          new_latch;
  logic          new_power;
  logic          wr_ctrl;
  logic          rd_ctrl;
  logic          wr_array;
  logic          rd_array;
  logic          capture_ok;
  logic          read_ok;
  logic [DATA_W-1:0] field_mask;
  logic [DATA_W-1:0] wr_fields;
  logic [DATA_W-1:0] ctrl_rd;

  // reset image of the whole state
  localparam epc_state_type STATE_RESET = '{
    latch_en:  CTRL_RESET[LATCH_BIT],
    power_cmd: CTRL_RESET[POWER_BIT],
    lat_addr:  ADDR_ZERO,
    lat_data:  DATA_ZERO,
    lat_valid: 1'b0,
    rdata:     DATA_ZERO
  };

  // widths the decode and the latches were built for
  if (ADDR_BITS != ADDR_W) begin : g_bad_addr
    $error("address width must equal the cpu bus width");
  end

  if (DATA_BITS != DATA_W) begin : g_bad_data
    $error("data width must equal the cpu bus width");
  end

  // control fields must fit and stay apart
  if (DATA_BITS <= LATCH_BIT || DATA_BITS <= POWER_BIT) begin : g_bad_field
    $error("control fields must fit inside the data width");
  end

  if (LATCH_BIT == POWER_BIT) begin : g_bad_place
    $error("control fields must not overlap");
  end

  // memory map sanity
  if (EPROM_FIRST > EPROM_LAST) begin : g_bad_window
    $error("eprom window must not be empty");
  end

  if (CTRL_ADDR >= EPROM_FIRST && CTRL_ADDR <= EPROM_LAST) begin : g_bad_map
    $error("control register must sit outside the eprom window");
  end

  // register image of the two control bits, unused bits zero
  function automatic logic [DATA_W-1:0] ctrl_image(
    input logic latch_bit,
    input logic power_bit
  );
    ctrl_image            = DATA_ZERO; // see [R11]
    ctrl_image[LATCH_BIT] = latch_bit; // see [R1]
    ctrl_image[POWER_BIT] = power_bit;
  endfunction

  // writable positions of the control register
  for (genvar i = 0; i < DATA_W; i++) begin : g_mask
    assign field_mask[i] = (i == LATCH_BIT) || (i == POWER_BIT);
  end

  // decode of the eprom window
  function automatic logic in_array(input logic [ADDR_W-1:0] a);
    in_array = (a >= EPROM_FIRST) && (a <= EPROM_LAST);
  endfunction

  // supply sense pin comes from outside the clock domain
  epc_sync3 u_vpp_sync (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .pin_in    (vpp_present),
    .level_out (vpp_ok)
  );

  // address decode
  assign hit_ctrl  = (bus_req.addr == CTRL_ADDR);
  assign hit_array = in_array(bus_req.addr);

  // strobes qualified by the decoded target
  assign wr_ctrl  = bus_req.wr & hit_ctrl;
  assign rd_ctrl  = bus_req.rd & hit_ctrl;
  assign wr_array = bus_req.wr & hit_array;
  assign rd_array = bus_req.rd & hit_array;

  // upper bits of a control write never reach the state
  assign wr_fields = bus_req.wdata & field_mask; // see [R11]

  // latch bit accepted only with supply present
  assign new_latch = wr_fields[LATCH_BIT] & vpp_ok; // see [R4]

  // power bit only together with an accepted latch bit
  assign new_power = wr_fields[POWER_BIT] & new_latch; // see [R7]

  // capture and read permissions follow the current mode
  assign capture_ok = wr_array & st_q.latch_en; // see [R2]
  assign read_ok    = rd_array & ~st_q.latch_en; // see [R3]

  // readback image of the current control bits
  assign ctrl_rd = ctrl_image(st_q.latch_en, st_q.power_cmd); // see [R1]

  // next state
  always_comb begin
    st_d = st_q;
    // control register write, upper bits dropped
    if (wr_ctrl) begin
      st_d.latch_en  = new_latch; // see [R1]
      st_d.power_cmd = new_power; // see [R10]
    end
    // power bit never outlives the latch enable
    if (!st_d.latch_en) begin
      st_d.power_cmd = 1'b0; // see [R7]
    end
    // capture address and data of an array write in programming mode
    if (capture_ok) begin
      st_d.lat_addr  = bus_req.addr; // see [R2]
      st_d.lat_data  = bus_req.wdata; // see [R2]
      st_d.lat_valid = 1'b1;
    end
    // leaving programming mode drops the held capture
    if (!st_d.latch_en) begin
      st_d.lat_valid = 1'b0; // see [R5]
    end
    // registered read answer
    if (rd_ctrl) begin
      st_d.rdata = ctrl_rd; // see [R11]
    end else if (read_ok) begin
      st_d.rdata = array_rdata; // see [R5]
    end else if (bus_req.rd) begin
      st_d.rdata = DATA_ZERO; // see [R3]
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= STATE_RESET; // see [R1]
    end else begin
      st_q <= st_d;
    end
  end

  // array drive: held capture in programming mode, cpu address otherwise
  always_comb begin
    array_out.prog_mode = st_q.latch_en; // see [R3]
    if (st_q.latch_en) begin
      array_out.addr    = st_q.lat_addr; // see [R2]
      array_out.data    = st_q.lat_data;
      array_out.read_en = 1'b0; // see [R3]
    end else begin
      array_out.addr    = bus_req.addr; // see [R5]
      array_out.data    = DATA_ZERO;
      array_out.read_en = rd_array;
    end
    // power follows the command bit only
    array_out.prog_power = st_q.power_cmd; // see [R6] see [R8]
  end

  assign bus_rdata   = st_q.rdata;
  assign latch_valid = st_q.lat_valid;

endmodule

// File: dv/epc_array_model.sv
`timescale 1ns/1ps
module epc_array_model
  import epc_pkg::*;
(
  input  wire epc_array_type array_out,
  output logic [DATA_W-1:0]  array_rdata
);
  // cells hold an address pattern; an idle bus shows the inverted address
  assign array_rdata = array_out.read_en ? array_out.addr[7:0] ^ 8'h5a
                                         : ~array_out.addr[7:0];
endmodule

// File: dv/epc_prog_ctrl_asserts.sv
`timescale 1ns/1ps
module epc_prog_ctrl_asserts
  import epc_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire epc_bus_req_type   bus_req,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic              vpp_present,
  input wire logic [DATA_W-1:0] array_rdata,
  input wire epc_array_type     array_out,
  input wire logic              latch_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // decoded accesses
  wire ctl = bus_req.addr == CTRL_ADDR;
  wire arr = bus_req.addr >= EPROM_FIRST && bus_req.addr <= EPROM_LAST;
  wire lat = array_out.prog_mode;
  wire pwr = array_out.prog_power;
  chk_power_latch: assert property (pwr |-> lat)
    else $error("power on without latch enable");
  chk_read_block: assert property (lat |-> !array_out.read_en)
    else $error("array read during programming");
  chk_read_route: assert property (!lat |->
    array_out.addr == bus_req.addr && array_out.data == DATA_ZERO)
    else $error("path not routed for reads");
  // five low samples: the synchroniser has then agreed on absent
  chk_vpp_block: assert property (!vpp_present [*5] ##0 !lat |=> !lat)
    else $error("latch set without voltage");
  chk_clear_both: assert property (bus_req.wr && ctl &&
    bus_req.wdata[1:0] == 2'b00 |=> !lat && !pwr)
    else $error("clear of both bits not taken");
  chk_power_set: assert property (vpp_present [*5] ##0
    (bus_req.wr && ctl && bus_req.wdata[1:0] == 2'b11 && lat) |=> pwr)
    else $error("power not switched on");
  chk_capture: assert property (lat && bus_req.wr && arr |=>
    latch_valid && array_out.addr == $past(bus_req.addr)
    && array_out.data == $past(bus_req.wdata))
    else $error("array write not captured");
  chk_ctl_read: assert property (bus_req.rd && ctl |=>
    bus_rdata == {6'h00, $past(lat), $past(pwr)})
    else $error("control read wrong");
  chk_arr_read: assert property (bus_req.rd && arr |=>
    bus_rdata == ($past(lat) ? DATA_ZERO : $past(array_rdata)))
    else $error("array read wrong");
endmodule
bind epc_prog_ctrl epc_prog_ctrl_asserts u_epc_prog_ctrl_asserts (
  .core_clk, .nrst, .bus_req, .bus_rdata, .vpp_present, .array_rdata,
  .array_out, .latch_valid);

// File: dv/tb_eprom_program_control.sv
`timescale 1ns/1ps
module tb_eprom_program_control;
  import epc_pkg::*;
  logic              core_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              vpp_present = 1'b0;
  epc_bus_req_type   bus_req = '0;
  logic [DATA_W-1:0] bus_rdata;
  logic [DATA_W-1:0] array_rdata;
  epc_array_type     array_out;
  logic              latch_valid;
  logic [DATA_W-1:0] st;
  int                num_errors = 0;
  int                samples_checked = 0;
  // control bits as a register image
  assign st = {6'h00, array_out.prog_mode, array_out.prog_power};
  always #25 core_clk = ~core_clk;
  epc_prog_ctrl u_epc_prog_ctrl (.core_clk(core_clk), .nrst(nrst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .vpp_present(vpp_present),
    .array_rdata(array_rdata), .array_out(array_out),
    .latch_valid(latch_valid));
  epc_array_model u_epc_array_model (.array_out(array_out),
    .array_rdata(array_rdata));
  task automatic chk(input logic [DATA_W-1:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one strobe cycle, then settle past the taking edge
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #20us;
    num_errors++;
    report_and_stop();
  end
  // programming sequence with refusals
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    acc(0, CTRL_ADDR, 8'h00); chk(bus_rdata, 8'h00);
    acc(1, CTRL_ADDR, 8'hff); acc(0, CTRL_ADDR, 8'h00);
    chk(bus_rdata, 8'h00);
    @(posedge core_clk);
    vpp_present <= 1'b1;
    repeat (4) @(posedge core_clk);
    acc(1, CTRL_ADDR, 8'h01); chk(st, 8'h00);
    acc(1, 14'h2005, 8'h3c); chk(latch_valid, 8'h00);
    acc(0, 14'h2005, 8'h00); chk(bus_rdata, 8'h5f);
    acc(1, CTRL_ADDR, 8'hfe); acc(0, CTRL_ADDR, 8'h00);
    chk(bus_rdata, 8'h02);
    acc(0, 14'h2005, 8'h00); chk(bus_rdata, 8'h00);
    acc(1, 14'h2123, 8'ha5); chk(array_out.data, 8'ha5);
    chk(array_out.addr[7:0], 8'h23);
    acc(1, CTRL_ADDR, 8'h03); chk(st, 8'h03);
    acc(1, CTRL_ADDR, 8'h00); chk(st, 8'h00);
    chk(latch_valid, 8'h00);
    report_and_stop();
  end
endmodule
